/* logic/tsc_pkg.sv */
// package for the task switch control block: register map, field positions, types
// assumes a 32-bit avalon-mm slave with word-aligned byte addresses
package tsc_pkg;
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_CMD        = 8'h04;
    localparam logic [7:0]  OFS_MCW        = 8'h08;
    localparam logic [7:0]  OFS_FLAGS      = 8'h0C;
    localparam logic [7:0]  OFS_TR_SEL     = 8'h10;
    localparam logic [7:0]  OFS_TR_BASE    = 8'h14;
    localparam logic [7:0]  OFS_TR_LIMIT   = 8'h18;
    localparam logic [7:0]  OFS_DESC       = 8'h1C;
    localparam logic [7:0]  OFS_STATUS     = 8'h20;
    localparam logic [7:0]  OFS_FAULT      = 8'h24;
    localparam logic [7:0]  OFS_DBASE      = 8'h28;
    localparam logic [7:0]  OFS_DLIMIT     = 8'h2C;
    localparam logic [7:0]  OFS_BACKLINK   = 8'h30;
    localparam int          POS_PE         = 0;
    localparam int          POS_MP         = 1;
    localparam int          POS_TS         = 3;
    localparam int          POS_NT         = 14;
    localparam int          POS_VM         = 17;
    localparam logic [3:0]  TYPE_TSS32_AV  = 4'h9;
    localparam logic [3:0]  TYPE_TSS32_BSY = 4'hB;
    localparam logic [3:0]  TYPE_TSS16_AV  = 4'h1;
    localparam logic [3:0]  TYPE_TSS16_BSY = 4'h3;
    localparam logic [7:0]  EXC_NONE       = 8'hFF;
    localparam logic [7:0]  EXC_DEBUG      = 8'h01;
    localparam logic [7:0]  EXC_NO_FPU     = 8'h07;
    localparam logic [7:0]  EXC_GP         = 8'h0D;
    localparam logic [3:0]  SAVE_CYCLES    = 4'h8;
    localparam logic [3:0]  LOAD_CYCLES    = 4'h8;
    localparam logic [31:0] MCW_RESET      = 32'h0000_0000;
    localparam logic [31:0] FLAGS_RESET    = 32'h0000_0002;
    // command codes written to the command register
    localparam logic [2:0]  CMD_JMP        = 3'h1;
    localparam logic [2:0]  CMD_CALL       = 3'h2;
    localparam logic [2:0]  CMD_INT        = 3'h3;
    localparam logic [2:0]  CMD_INTERRUPT_RETURN       = 3'h4;
    localparam logic [2:0]  CMD_INT_NOTASK = 3'h5;
    localparam logic [2:0]  CMD_HDL_DONE   = 3'h6;
    localparam logic [2:0]  CMD_FPU        = 3'h7;

    typedef enum logic [4:0] {
        TSC_IDLE  = 5'b00001,
        TSC_CHECK = 5'b00010,
        TSC_SAVE  = 5'b00100,
        TSC_LOAD  = 5'b01000,
        TSC_DONE  = 5'b10000
    } tsc_state_t;

    // descriptor of the incoming task as staged by software
    typedef struct packed {
        logic [15:0] sel;
        logic [3:0]  dtype;
        logic        gate;
        logic        trap;
        logic        vm;
        logic        nt;
    } tsc_desc_t;
endpackage

/* logic/tsc_top.sv */
// task switch control: sequences save/load of task state, busy marking, back link,
// flag updates and related faults; software stages descriptors over avalon-mm.
// assumes one clock, registers reached through an avalon-mm slave with waitrequest.
// Notes on behaviour
// - far jump/call to state segment switches
// - interrupt through task gate switches tasks
// - task register load also loads base, limit
// - interrupt return switches back when nested set
// - call/int marks busy, links back, sets nested
// - non-switch interrupt clears nested, restores later
// - busy type 9 to B, 1 to 3
// - busy target of jump/call/int raises general protection 13
// - virtual 8086 only entered via task switch
// - every switch sets task switched flag
// - fpu use with switched and monitor faults 7
// - debug trap flag raises exception 1
// - reset starts in real mode
// - protection enable write enters protected mode
// - nested return saves then restores earlier task
// - check, save, load, then resume
`timescale 1ns/1ps
module tsc_top
    import tsc_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    input  wire logic [7:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    output logic             issue_hold_out,
    output logic             protected_mode_out,
    output logic             real_addr_mode_out,
    output logic             exc_valid_out,
    output logic      [7:0]  exc_vector_out
);
    logic             rst_s1_q;
    logic             rst_n;
    tsc_state_t       state_q, state_d;
    logic [3:0]       cnt_q, cnt_d;
    logic [31:0]      mcw_q, mcw_d;
    logic [31:0]      flags_q, flags_d;
    logic [15:0]      tr_sel_q, tr_sel_d;
    logic [31:0]      tr_base_q, tr_base_d;
    logic [31:0]      tr_limit_q, tr_limit_d;
    tsc_desc_t        desc_q, desc_d;
    logic [31:0]      dbase_q, dbase_d;
    logic [31:0]      dlimit_q, dlimit_d;
    logic [2:0]       cmd_q, cmd_d;
    logic [15:0]      backlink_q, backlink_d;
    logic [3:0]       wr_type_q, wr_type_d;
    logic             saved_nt_q, saved_nt_d;
    logic             exc_valid_q, exc_valid_d;
    logic [7:0]       exc_vec_q, exc_vec_d;
    logic [31:0]      rdata_q, rdata_d;
    logic             wait_q, wait_d;
    logic             go;
    logic             wr;
    logic             rd;

    function automatic logic is_busy(input logic [3:0] t);
        return (t == TYPE_TSS32_BSY) || (t == TYPE_TSS16_BSY);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // async assert, synchronous release
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // one wait cycle per access; writes during a switch are answered after it ends, reads are answered at once
    assign wr = avs_write_in && wait_q && state_q == TSC_IDLE;
    assign rd = avs_read_in && wait_q;
    assign go = wr && avs_address_in == OFS_CMD;

    always_comb begin
        state_d     = state_q;
        cnt_d       = cnt_q;
        mcw_d       = mcw_q;
        flags_d     = flags_q;
        tr_sel_d    = tr_sel_q;
        tr_base_d   = tr_base_q;
        tr_limit_d  = tr_limit_q;
        desc_d      = desc_q;
        dbase_d     = dbase_q;
        dlimit_d    = dlimit_q;
        cmd_d       = cmd_q;
        backlink_d  = backlink_q;
        wr_type_d   = wr_type_q;
        saved_nt_d  = saved_nt_q;
        exc_valid_d = 1'b0;
        exc_vec_d   = exc_vec_q;
        rdata_d     = rdata_q;
        wait_d      = 1'b1;
        if ((avs_read_in || avs_write_in) && wait_q) begin
            if (avs_read_in || state_q == TSC_IDLE) begin
                wait_d = 1'b0;
            end
        end
        if (wr) begin
            case (avs_address_in)
                OFS_MCW: mcw_d = merge(mcw_q, avs_writedata_in, avs_byteenable_in);
                OFS_FLAGS: begin
                    flags_d = merge(flags_q, avs_writedata_in, avs_byteenable_in);
                    flags_d[POS_VM] = flags_q[POS_VM];
                end
                OFS_TR_SEL: begin
                    tr_sel_d   = avs_writedata_in[15:0];
                    tr_base_d  = dbase_q;
                    tr_limit_d = dlimit_q;
                end
                OFS_DESC:   desc_d   = tsc_desc_t'(avs_writedata_in[23:0]);
                OFS_DBASE:  dbase_d  = avs_writedata_in;
                OFS_DLIMIT: dlimit_d = avs_writedata_in;
                default: ;
            endcase
        end
        if (rd) begin
            case (avs_address_in)
                OFS_CTRL:     rdata_d = {30'h0, real_addr_mode_out, mcw_q[POS_PE]};
                OFS_MCW:      rdata_d = mcw_q;
                OFS_FLAGS:    rdata_d = flags_q;
                OFS_TR_SEL:   rdata_d = {16'h0, tr_sel_q};
                OFS_TR_BASE:  rdata_d = tr_base_q;
                OFS_TR_LIMIT: rdata_d = tr_limit_q;
                OFS_DESC:     rdata_d = {8'h0, desc_q};
                OFS_STATUS:   rdata_d = {23'h0, state_q, wr_type_q};
                OFS_FAULT:    rdata_d = {24'h0, exc_vec_q};
                OFS_DBASE:    rdata_d = dbase_q;
                OFS_DLIMIT:   rdata_d = dlimit_q;
                OFS_BACKLINK: rdata_d = {16'h0, backlink_q};
                default:      rdata_d = 32'h0;
            endcase
        end
        case (state_q)
            TSC_IDLE: begin
                if (go) begin
                    cmd_d = avs_writedata_in[2:0];
                    case (avs_writedata_in[2:0])
                        CMD_JMP, CMD_CALL: state_d = TSC_CHECK;
                        CMD_INT: begin
                            if (desc_q.gate) begin
                                state_d = TSC_CHECK;
                            end
                        end
                        CMD_INTERRUPT_RETURN: begin
                            if (flags_q[POS_NT]) begin
                                state_d = TSC_CHECK;
                            end
                        end
                        CMD_INT_NOTASK: begin
                            saved_nt_d = flags_q[POS_NT];
                            flags_d[POS_NT] = 1'b0;
                        end
                        CMD_HDL_DONE: flags_d[POS_NT] = saved_nt_q;
                        CMD_FPU: begin
                            if (mcw_q[POS_TS] && mcw_q[POS_MP]) begin
                                exc_valid_d = 1'b1;
                                exc_vec_d   = EXC_NO_FPU;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            TSC_CHECK: begin
                // return targets are busy by design; only entering switches check
                if (is_busy(desc_q.dtype) && cmd_q != CMD_INTERRUPT_RETURN) begin
                    exc_valid_d = 1'b1;
                    exc_vec_d   = EXC_GP;
                    state_d     = TSC_IDLE;
                end else begin
                    cnt_d   = SAVE_CYCLES;
                    state_d = TSC_SAVE;
                end
            end
            TSC_SAVE: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    cnt_d   = LOAD_CYCLES;
                    state_d = TSC_LOAD;
                end
            end
            TSC_LOAD: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    state_d = TSC_DONE;
                end
            end
            TSC_DONE: begin
                if (cmd_q == CMD_CALL || cmd_q == CMD_INT) begin
                    backlink_d = tr_sel_q;
                    flags_d[POS_NT] = 1'b1;
                end else begin
                    backlink_d = 16'h0;
                    flags_d[POS_NT] = desc_q.nt;
                end
                case (desc_q.dtype)
                    TYPE_TSS32_AV: wr_type_d = TYPE_TSS32_BSY;
                    TYPE_TSS16_AV: wr_type_d = TYPE_TSS16_BSY;
                    default:       wr_type_d = desc_q.dtype;
                endcase
                flags_d[POS_VM] = desc_q.vm;
                mcw_d[POS_TS]   = 1'b1;
                tr_sel_d        = desc_q.sel;
                tr_base_d       = dbase_q;
                tr_limit_d      = dlimit_q;
                if (desc_q.trap) begin
                    exc_valid_d = 1'b1;
                    exc_vec_d   = EXC_DEBUG;
                end
                state_d = TSC_IDLE;
            end
            default: state_d = TSC_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= TSC_IDLE;
            cnt_q       <= 4'h0;
            mcw_q       <= MCW_RESET;
            flags_q     <= FLAGS_RESET;
            tr_sel_q    <= 16'h0;
            tr_base_q   <= 32'h0;
            tr_limit_q  <= 32'h0;
            desc_q      <= '0;
            dbase_q     <= 32'h0;
            dlimit_q    <= 32'h0;
            cmd_q       <= 3'h0;
            backlink_q  <= 16'h0;
            wr_type_q   <= 4'h0;
            saved_nt_q  <= 1'b0;
            exc_valid_q <= 1'b0;
            exc_vec_q   <= EXC_NONE;
            rdata_q     <= 32'h0;
            wait_q      <= 1'b1;
        end else begin
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            mcw_q       <= mcw_d;
            flags_q     <= flags_d;
            tr_sel_q    <= tr_sel_d;
            tr_base_q   <= tr_base_d;
            tr_limit_q  <= tr_limit_d;
            desc_q      <= desc_d;
            dbase_q     <= dbase_d;
            dlimit_q    <= dlimit_d;
            cmd_q       <= cmd_d;
            backlink_q  <= backlink_d;
            wr_type_q   <= wr_type_d;
            saved_nt_q  <= saved_nt_d;
            exc_valid_q <= exc_valid_d;
            exc_vec_q   <= exc_vec_d;
            rdata_q     <= rdata_d;
            wait_q      <= wait_d;
        end
    end

    // outputs straight from flip-flops; hold registered from the next state
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            issue_hold_out     <= 1'b0;
            protected_mode_out <= 1'b0;
            real_addr_mode_out <= 1'b1;
        end else begin
            issue_hold_out     <= state_d != TSC_IDLE;
            protected_mode_out <= mcw_d[POS_PE];
            real_addr_mode_out <= !mcw_d[POS_PE] || flags_d[POS_VM];
        end
    end

    assign avs_readdata_out    = rdata_q;
    assign avs_waitrequest_out = wait_q;
    assign exc_valid_out       = exc_valid_q;
    assign exc_vector_out      = exc_vec_q;
endmodule

/* sim/tsc_top_sva.sv */
// checker for tsc_top: sequencing and fault relations seen at the top ports
// assumes tsc_pkg offsets and vectors; bound to every tsc_top instance
`timescale 1ns/1ps
module tsc_top_sva
    import tsc_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        reset_n_in,
    input wire logic [7:0]  avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0]  avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    input wire logic        issue_hold_out,
    input wire logic        protected_mode_out,
    input wire logic        real_addr_mode_out,
    input wire logic        exc_valid_out,
    input wire logic [7:0]  exc_vector_out
);
    wire logic wr_acc = avs_write_in && !avs_waitrequest_out;
    wire logic pe_wr  = wr_acc && avs_address_in == OFS_MCW && avs_writedata_in[0] && avs_byteenable_in[0];
    wire logic fpu_wr = wr_acc && avs_address_in == OFS_CMD && avs_writedata_in[2:0] == CMD_FPU;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    AST_REAL_WHEN_UNPROTECTED: assert property (!protected_mode_out |-> real_addr_mode_out)
        else $error("real mode not reported while protection is off");
    // the control word write is taken one edge before its answer, so the rise meets the answer cycle
    AST_PE_ENTRY: assert property ($rose(protected_mode_out) |-> pe_wr)
        else $error("protected mode entered without a control word write");
    AST_GP_FROM_CHECK: assert property (exc_valid_out && exc_vector_out == EXC_GP |-> $past(issue_hold_out))
        else $error("general protection raised outside a switch check");
    AST_DEBUG_AFTER_LOAD: assert property (exc_valid_out && exc_vector_out == EXC_DEBUG |-> $past(issue_hold_out, 8))
        else $error("debug trap raised before the new state was loaded");
    AST_FPU_CAUSE: assert property (exc_valid_out && exc_vector_out == EXC_NO_FPU |->
        fpu_wr)
        else $error("coprocessor fault without a floating-point command");
    AST_EXC_ONE_CYCLE: assert property (exc_valid_out |=> !exc_valid_out)
        else $error("exception pulse longer than one cycle");
    AST_SWITCH_BOUNDED: assert property ($rose(issue_hold_out) |-> ##[1:40] !issue_hold_out)
        else $error("switch sequencing did not finish");
    AST_WRITE_HELD_OFF: assert property (issue_hold_out && $past(issue_hold_out) && avs_write_in
        |-> avs_waitrequest_out)
        else $error("write answered during a switch");
endmodule
bind tsc_top tsc_top_sva tsc_top_sva_inst (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .issue_hold_out(issue_hold_out), .protected_mode_out(protected_mode_out),
    .real_addr_mode_out(real_addr_mode_out), .exc_valid_out(exc_valid_out), .exc_vector_out(exc_vector_out));

/* sim/tsc_mem_model.sv */
// descriptor table model: entries that software stages into the descriptor register
// assumes the {sel,type,gate,trap,vm,nt} packing of the descriptor register
`timescale 1ns/1ps
module tsc_mem_model;
    localparam logic [31:0] LIMIT32 = 32'h0000_0067;
    // table built before protection is enabled; entry 5 is the task the register starts on
    function automatic logic [31:0] entry(input int k);
        case (k)
            0: entry = 32'h0000_3094;
            1: entry = 32'h0000_3810;
            2: entry = 32'h0000_30B0;
            3: entry = 32'h0000_3830;
            4: entry = 32'h0000_409A;
            default: entry = 32'h0000_2890;
        endcase
    endfunction
endmodule

/* sim/tb_top.sv */
// testbench for tsc_top: avalon-mm master tasks and directed task switch tests
// assumes tsc_pkg, the bound checker and the descriptor model tsc_mem_model
`timescale 1ns/1ps
module tb_top
    import tsc_pkg::*;
;
    logic        clk_in = 1'b0, reset_n_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
    logic [7:0]  avs_address_in = 8'h00;
    logic [31:0] avs_writedata_in = 32'h0000_0000, rd;
    logic [3:0]  avs_byteenable_in = 4'hF;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out, issue_hold_out, protected_mode_out, real_addr_mode_out, exc_valid_out;
    logic [7:0]  exc_vector_out, exc_last = 8'hFF;
    int          fail_count = 0, compares = 0, exc_cnt = 0, hold_len = 0, e;

    always #12.5 clk_in = ~clk_in;
    tsc_top tsc_top_inst (.clk_in(clk_in), .reset_n_in(reset_n_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .issue_hold_out(issue_hold_out),
        .protected_mode_out(protected_mode_out), .real_addr_mode_out(real_addr_mode_out),
        .exc_valid_out(exc_valid_out), .exc_vector_out(exc_vector_out));
    tsc_mem_model tsc_mem_model_inst ();

    always @(posedge clk_in) begin
        if (exc_valid_out === 1'b1) begin
            exc_cnt++;
            exc_last = exc_vector_out;
        end
        if (issue_hold_out === 1'b1) hold_len++;
    end

    task automatic tally_and_finish;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // the request is held until waitrequest is sampled low; no answer within 99 cycles counts as a failure
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        avs_address_in   <= a;
        avs_writedata_in <= d;
        avs_write_in     <= wr;
        avs_read_in      <= !wr;
        do begin
            @(posedge clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 100);
        rd = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in  <= 1'b0;
        if (n >= 100) check("bus answer", 32'h0, 32'h1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(nm, rd, exp);
    endtask
    task automatic cmd(input logic [2:0] c);
        hold_len = 0;
        e = exc_cnt;
        wr(OFS_CMD, {29'h0, c});
        // a write issued during a switch is held off until the engine is idle
        wr(8'h3C, 32'h0);
        check("hold after write", issue_hold_out, 32'h0);
        repeat (2) @(posedge clk_in);
    endtask

    initial begin
        repeat (8000) @(posedge clk_in);
        fail_count++;
        tally_and_finish;
    end

    initial begin
        repeat (4) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        check("protected", protected_mode_out, 32'h0);
        rdc("ctrl", OFS_CTRL, 32'h2);
        rdc("mcw", OFS_MCW, MCW_RESET);
        rdc("flags", OFS_FLAGS, FLAGS_RESET);
        rdc("fault", OFS_FAULT, 32'hFF);
        wr(OFS_MCW, 32'h1);
        wr(OFS_DBASE, 32'h0001_2000);
        wr(OFS_DLIMIT, tsc_mem_model_inst.LIMIT32);
        wr(OFS_TR_SEL, 32'h28);
        rdc("ctrl", OFS_CTRL, 32'h1);
        check("real", real_addr_mode_out, 32'h0);
        rdc("tr base", OFS_TR_BASE, 32'h0001_2000);
        rdc("tr limit", OFS_TR_LIMIT, tsc_mem_model_inst.LIMIT32);
        wr(8'h3C, 32'hFFFF_FFFF);
        rdc("unmapped", 8'h3C, 32'h0);
        wr(OFS_DESC, tsc_mem_model_inst.entry(5));
        cmd(CMD_JMP);
        check("jmp hold", hold_len >= 16, 32'h1);
        rdc("jmp type", OFS_STATUS, 32'h1B);
        rdc("jmp flags", OFS_FLAGS, FLAGS_RESET);
        rdc("jmp mcw", OFS_MCW, 32'h9);
        $display("test reset and protected entry done");
        for (int k = 0; k < 2; k++) begin
            wr(OFS_DESC, tsc_mem_model_inst.entry(k));
            cmd(CMD_CALL);
            check("hold", hold_len >= 16, 32'h1);
            rdc("type", OFS_STATUS, 32'h1B - 8 * k);
            rdc("backlink", OFS_BACKLINK, 32'h28 + 8 * k);
            rdc("tr sel", OFS_TR_SEL, 32'h30 + 8 * k);
            rdc("flags", OFS_FLAGS, FLAGS_RESET | 32'h4000);
            rdc("mcw", OFS_MCW, 32'h9);
            check("debug count", exc_cnt - e, 32'h1 - k);
        end
        check("debug vector", exc_last, EXC_DEBUG);
        for (int k = 2; k < 4; k++) begin
            wr(OFS_DESC, tsc_mem_model_inst.entry(k));
            cmd(CMD_JMP);
            check("busy fault", exc_last, EXC_GP);
            check("busy count", exc_cnt - e, 32'h1);
            rdc("fault", OFS_FAULT, EXC_GP);
        end
        $display("test call and busy done");
        wr(OFS_DESC, tsc_mem_model_inst.entry(5));
        cmd(CMD_INTERRUPT_RETURN);
        check("interrupt_return hold", hold_len >= 16, 32'h1);
        rdc("tr sel", OFS_TR_SEL, 32'h28);
        rdc("flags", OFS_FLAGS, FLAGS_RESET);
        cmd(CMD_INTERRUPT_RETURN);
        check("plain interrupt_return", hold_len, 32'h0);
        wr(OFS_FLAGS, FLAGS_RESET | 32'h4000);
        cmd(CMD_INT_NOTASK);
        rdc("nt cleared", OFS_FLAGS, FLAGS_RESET);
        cmd(CMD_HDL_DONE);
        rdc("nt restored", OFS_FLAGS, FLAGS_RESET | 32'h4000);
        wr(OFS_FLAGS, FLAGS_RESET | 32'h2_0000);
        repeat (3) @(posedge clk_in);
        check("vm write", real_addr_mode_out, 32'h0);
        cmd(CMD_INT);
        check("int no gate", hold_len, 32'h0);
        wr(OFS_DESC, tsc_mem_model_inst.entry(4));
        cmd(CMD_INT);
        check("int gate", hold_len >= 16, 32'h1);
        check("vm real", real_addr_mode_out, 32'h1);
        rdc("flags", OFS_FLAGS, FLAGS_RESET | 32'h2_4000);
        $display("test return and interrupt done");
        wr(OFS_MCW, 32'hB);
        cmd(CMD_FPU);
        check("fpu fault", exc_last, EXC_NO_FPU);
        check("fpu count", exc_cnt - e, 32'h1);
        wr(OFS_MCW, 32'h9);
        cmd(CMD_FPU);
        check("fpu no mp", exc_cnt - e, 32'h0);
        $display("test coprocessor done");
        tally_and_finish;
    end
endmodule
